// ### pkg/pfpp_pkg.sv
// shared constants and types for the parallel flash page programmer
package pfpp_pkg;
    localparam logic [1:0] PFPP_MODE_ADDR = 2'h0;
    localparam logic [1:0] PFPP_MODE_DATA = 2'h1;
    localparam logic [1:0] PFPP_MODE_CMD  = 2'h2;
    localparam logic [7:0] PFPP_CMD_WRITE_FLASH = 8'h10;
    localparam logic [7:0] PFPP_CMD_NOP         = 8'h00;
    localparam logic [7:0] PFPP_CMD_RST         = 8'h00;
    localparam int         PFPP_PAGE_WORDS      = 64;
    localparam int         PFPP_NUM_PAGES       = 128;
    localparam int         PFPP_PROG_CYCLES     = 200;
    localparam int         PFPP_PULSE_CYCLES    = 2;
    typedef enum logic [2:0] {
        PFPP_H_IDLE, PFPP_H_SETUP, PFPP_H_PULSE, PFPP_H_HOLD, PFPP_H_WAIT
    } pfpp_hstate_e;
endpackage : pfpp_pkg

// ### pkg/pfpp_if.sv
// pin bundle between the external programmer and the flash page programmer
`timescale 1ns/10ps
`default_nettype none
interface pfpp_if;
    logic       mode_select_hi;
    logic       mode_select_lo;
    logic       byte_select;
    logic       load_strobe_pin;
    logic       page_latch_pin;
    logic       wr_n;
    logic [7:0] data;
    logic       ready_busy_out;
    modport device (
        input  mode_select_hi, mode_select_lo, byte_select, load_strobe_pin,
        input  page_latch_pin, wr_n, data,
        output ready_busy_out
    );
    modport host (
        output mode_select_hi, mode_select_lo, byte_select, load_strobe_pin,
        output page_latch_pin, wr_n, data,
        input  ready_busy_out
    );
endinterface : pfpp_if
`default_nettype wire

// ### rtl/pfpp_device.sv
// device end: command/address/data loading, page buffer and page write
//
// Functional notes
// [RULE_01] mode 10 strobe loads command byte
// [RULE_02] command 0x10 with bs 0 selects write
// [RULE_03] mode 00 strobe loads address byte
// [RULE_04] byte-select picks low or high address
// [RULE_05] mode 01 strobe loads data byte
// [RULE_06] bs 1 data byte is high half
// [RULE_07] page latch with bs 1 stores word
// [RULE_08] page buffer programs page at once
// [RULE_09] low address bits word, high bits page
// [RULE_10] upper low-byte bits join page address
// [RULE_11] wr low with bs 0 starts programming
// [RULE_12] ready returns high after programming completes
// [RULE_13] programmer repeats load steps then programs
// [RULE_14] last command persists until replaced
`timescale 1ns/10ps
`default_nettype none
module pfpp_device
    import pfpp_pkg::*;
#(
    parameter int PAGE_WORDS  = PFPP_PAGE_WORDS,
    parameter int NUM_PAGES   = PFPP_NUM_PAGES,
    parameter int PROG_CYCLES = PFPP_PROG_CYCLES
) (
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_rstn,
    pfpp_if.device                    pins,
    input  wire logic [$clog2(PAGE_WORDS*NUM_PAGES)-1:0] i_rd_addr,
    output logic [15:0]               o_rd_data,
    output logic                      o_prog_done,
    output logic                      o_write_mode
);
    localparam int WW = $clog2(PAGE_WORDS);
    localparam int AW = $clog2(PAGE_WORDS * NUM_PAGES);
    localparam int PW = AW - WW;
    localparam int CW = $clog2(PROG_CYCLES + 1);

    logic [15:0] flash_mem [PAGE_WORDS*NUM_PAGES];
    logic [15:0] page_buf  [PAGE_WORDS];

    logic          ready_r;
    logic          wmode_r, wmode_nxt;
    logic [7:0]    addr_lo_r, addr_lo_nxt, addr_hi_r, addr_hi_nxt;
    logic [7:0]    dlo_r, dlo_nxt, dhi_r, dhi_nxt;
    logic          ls_q_r, pl_q_r, wr_q_r;
    logic          busy_r, busy_nxt, done_r, done_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic [PW-1:0] page_r, page_nxt;
    logic [15:0]   rd_r;

    logic [1:0]    mode;
    logic          ls_rise, pl_rise, wr_fall;
    logic [15:0]   addr_full;

    assign mode      = {pins.mode_select_hi, pins.mode_select_lo};
    assign ls_rise   = pins.load_strobe_pin & ~ls_q_r;
    assign pl_rise   = pins.page_latch_pin & ~pl_q_r;
    assign wr_fall   = ~pins.wr_n & wr_q_r;
    assign addr_full = {addr_hi_r, addr_lo_r};

    always_comb begin
        wmode_nxt   = wmode_r;
        addr_lo_nxt = addr_lo_r;
        addr_hi_nxt = addr_hi_r;
        dlo_nxt     = dlo_r;
        dhi_nxt     = dhi_r;
        busy_nxt    = busy_r;
        done_nxt    = 1'b0;
        cnt_nxt     = cnt_r;
        page_nxt    = page_r;
        // strobes are ignored while a page is being programmed
        if (ls_rise && !busy_r) begin
            unique case (mode)
                // [RULE_01] command load
                PFPP_MODE_CMD: begin
                    // [RULE_02] [RULE_14] write mode held
                    wmode_nxt = (pins.data == PFPP_CMD_WRITE_FLASH) && !pins.byte_select;
                end
                // [RULE_03] [RULE_04] address byte load
                PFPP_MODE_ADDR: begin
                    if (pins.byte_select) begin
                        addr_hi_nxt = pins.data;
                    end else begin
                        addr_lo_nxt = pins.data;
                    end
                end
                // [RULE_05] [RULE_06] data byte load
                PFPP_MODE_DATA: begin
                    if (pins.byte_select) begin
                        dhi_nxt = pins.data;
                    end else begin
                        dlo_nxt = pins.data;
                    end
                end
                default: begin
                end
            endcase
        end
        // [RULE_11] start page program
        if (wr_fall && !pins.byte_select && wmode_r && !busy_r) begin
            busy_nxt = 1'b1;
            cnt_nxt  = CW'(PROG_CYCLES);
            // [RULE_09] [RULE_10] page from upper address bits
            page_nxt = addr_full[AW-1:WW];
        end else if (busy_r) begin
            if (cnt_r == CW'(1)) begin
                // [RULE_12] ready again
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end
            cnt_nxt = cnt_r - CW'(1);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            ready_r   <= 1'b1;
            wmode_r   <= 1'b0;
            addr_lo_r <= 8'h00;
            addr_hi_r <= 8'h00;
            dlo_r     <= 8'h00;
            dhi_r     <= 8'h00;
            ls_q_r    <= 1'b0;
            pl_q_r    <= 1'b0;
            wr_q_r    <= 1'b1;
            busy_r    <= 1'b0;
            done_r    <= 1'b0;
            cnt_r     <= '0;
            page_r    <= '0;
        end else begin
            // ready kept in its own flop so the pin has no gate after the register
            ready_r   <= ~busy_nxt;
            wmode_r   <= wmode_nxt;
            addr_lo_r <= addr_lo_nxt;
            addr_hi_r <= addr_hi_nxt;
            dlo_r     <= dlo_nxt;
            dhi_r     <= dhi_nxt;
            ls_q_r    <= pins.load_strobe_pin;
            pl_q_r    <= pins.page_latch_pin;
            wr_q_r    <= pins.wr_n;
            busy_r    <= busy_nxt;
            done_r    <= done_nxt;
            cnt_r     <= cnt_nxt;
            page_r    <= page_nxt;
        end
    end

    // memories carry no reset; content is undefined until written
    always_ff @(posedge i_clk_sys) begin
        // [RULE_07] [RULE_09] latch word into page buffer
        if (pl_rise && pins.byte_select && wmode_r && !busy_r) begin
            page_buf[addr_full[WW-1:0]] <= {dhi_r, dlo_r};
        end
        // [RULE_08] whole page committed at the end of programming
        if (busy_r && cnt_r == CW'(1)) begin
            for (int i = 0; i < PAGE_WORDS; i++) begin
                flash_mem[{page_r, WW'(i)}] <= page_buf[i];
            end
        end
        rd_r <= flash_mem[i_rd_addr];
    end

    assign o_rd_data         = rd_r;
    assign o_prog_done       = done_r;
    assign o_write_mode      = wmode_r;
    assign pins.ready_busy_out = ready_r;
endmodule : pfpp_device
`default_nettype wire

// ### rtl/pfpp_host.sv
// programmer end: drives one pin step per request with setup, pulse and hold
`timescale 1ns/10ps
`default_nettype none
module pfpp_host
    import pfpp_pkg::*;
#(
    parameter int PULSE_CYCLES = PFPP_PULSE_CYCLES
) (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rstn,
    pfpp_if.host            pins,
    input  wire logic       i_req,
    input  wire logic [1:0] i_kind,
    input  wire logic [1:0] i_mode,
    input  wire logic       i_bsel,
    input  wire logic [7:0] i_data,
    output logic            o_ready,
    output logic            o_done
);
    // i_kind: 0 load strobe, 1 page latch, 2 write pulse then wait for ready
    localparam int PCW = $clog2(PULSE_CYCLES + 1);
    pfpp_hstate_e   st_r, st_nxt;
    logic [1:0]     kind_r, kind_nxt, mode_r, mode_nxt;
    logic           bs_r, bs_nxt, ls_r, ls_nxt, pl_r, pl_nxt, wrn_r, wrn_nxt;
    logic           done_r, done_nxt;
    logic [7:0]     data_r, data_nxt;
    logic [PCW-1:0] cnt_r, cnt_nxt;

    always_comb begin
        st_nxt   = st_r;
        kind_nxt = kind_r;
        mode_nxt = mode_r;
        bs_nxt   = bs_r;
        data_nxt = data_r;
        ls_nxt   = 1'b0;
        pl_nxt   = 1'b0;
        wrn_nxt  = 1'b1;
        done_nxt = 1'b0;
        cnt_nxt  = cnt_r;
        unique case (st_r)
            PFPP_H_IDLE: begin
                if (i_req) begin
                    kind_nxt = i_kind;
                    mode_nxt = i_mode;
                    bs_nxt   = i_bsel;
                    data_nxt = i_data;
                    st_nxt   = PFPP_H_SETUP;
                end
            end
            PFPP_H_SETUP: begin
                // strobe rises one cycle after the pins settle, so it stands PULSE_CYCLES
                ls_nxt  = (kind_r == 2'h0);
                pl_nxt  = (kind_r == 2'h1);
                wrn_nxt = (kind_r != 2'h2);
                st_nxt  = PFPP_H_PULSE;
                cnt_nxt = PCW'(PULSE_CYCLES);
            end
            PFPP_H_PULSE: begin
                // [RULE_01] [RULE_03] [RULE_05] positive load pulse
                ls_nxt  = (kind_r == 2'h0);
                // [RULE_07] positive latch pulse
                pl_nxt  = (kind_r == 2'h1);
                // [RULE_11] negative write pulse
                wrn_nxt = (kind_r != 2'h2);
                cnt_nxt = cnt_r - PCW'(1);
                if (cnt_r == PCW'(1)) begin
                    ls_nxt  = 1'b0;
                    pl_nxt  = 1'b0;
                    wrn_nxt = 1'b1;
                    st_nxt  = (kind_r == 2'h2) ? PFPP_H_WAIT : PFPP_H_HOLD;
                end
            end
            // [RULE_12] [RULE_13] wait for ready before next step
            PFPP_H_WAIT: begin
                if (pins.ready_busy_out && !ls_r && wrn_r) begin
                    st_nxt = PFPP_H_HOLD;
                end
            end
            PFPP_H_HOLD: begin
                done_nxt = 1'b1;
                st_nxt   = PFPP_H_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            st_r   <= PFPP_H_IDLE;
            kind_r <= 2'h0;
            mode_r <= 2'h0;
            bs_r   <= 1'b0;
            data_r <= 8'h00;
            ls_r   <= 1'b0;
            pl_r   <= 1'b0;
            wrn_r  <= 1'b1;
            done_r <= 1'b0;
            cnt_r  <= '0;
        end else begin
            st_r   <= st_nxt;
            kind_r <= kind_nxt;
            mode_r <= mode_nxt;
            bs_r   <= bs_nxt;
            data_r <= data_nxt;
            ls_r   <= ls_nxt;
            pl_r   <= pl_nxt;
            wrn_r  <= wrn_nxt;
            done_r <= done_nxt;
            cnt_r  <= cnt_nxt;
        end
    end

    assign pins.mode_select_hi  = mode_r[1];
    assign pins.mode_select_lo  = mode_r[0];
    assign pins.byte_select     = bs_r;
    assign pins.data            = data_r;
    assign pins.load_strobe_pin = ls_r;
    assign pins.page_latch_pin  = pl_r;
    assign pins.wr_n            = wrn_r;
    assign o_ready              = (st_r == PFPP_H_IDLE);
    assign o_done               = done_r;
endmodule : pfpp_host
`default_nettype wire

// ### verif/pfpp_checker.sv
// pin-level checks between programmer end and device end
`timescale 1ns/10ps
`default_nettype none
module pfpp_checker
    import pfpp_pkg::*;
#(
    parameter int PROG_CYCLES = PFPP_PROG_CYCLES
) (
    input wire logic       i_clk_sys,
    input wire logic       i_rstn,
    input wire logic       i_mode_select_hi,
    input wire logic       i_mode_select_lo,
    input wire logic       i_byte_select,
    input wire logic       i_load_strobe_pin,
    input wire logic       i_page_latch_pin,
    input wire logic       i_wr_n,
    input wire logic [7:0] i_data,
    input wire logic       i_ready_busy_out
);
    localparam int P_LO = PROG_CYCLES - 1;
    localparam int P_HI = PROG_CYCLES + 2;
    logic [8:0] cmd_r;
    logic [8:0] cmd_nxt;
    logic       ls_r;
    logic       wr_ok;
    // shadow of the last command, so write acceptance can be judged
    always_comb begin
        cmd_nxt = cmd_r;
        if (i_load_strobe_pin && !ls_r && i_mode_select_hi && !i_mode_select_lo) begin
            cmd_nxt = {i_data, i_byte_select};
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            cmd_r <= 9'h000;
            ls_r  <= 1'b0;
        end else begin
            cmd_r <= cmd_nxt;
            ls_r  <= i_load_strobe_pin;
        end
    end
    assign wr_ok = (cmd_r == {PFPP_CMD_WRITE_FLASH, 1'b0});
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);
    property p_wr_start;
        $fell(i_wr_n) && !i_byte_select && wr_ok && i_ready_busy_out
            |-> ##[1:2] !i_ready_busy_out;
    endproperty
    a_wr_start: assert property (p_wr_start) else $error("busy not raised by write");
    property p_wr_refused;
        $fell(i_wr_n) && i_ready_busy_out && !(wr_ok && !i_byte_select)
            |=> i_ready_busy_out[*3];
    endproperty
    a_wr_refused: assert property (p_wr_refused) else $error("busy without write mode");
    property p_busy_cause;
        $fell(i_ready_busy_out) |-> !$past(i_wr_n, 1) || !$past(i_wr_n, 2);
    endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("busy with no write pulse");
    property p_busy_min;
        $fell(i_ready_busy_out) |-> !i_ready_busy_out[*8];
    endproperty
    a_busy_min: assert property (p_busy_min) else $error("busy ended early");
    property p_busy_end;
        $fell(i_ready_busy_out) |-> ##[P_LO:P_HI] i_ready_busy_out;
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("ready not returned");
    property p_no_step_busy;
        !i_ready_busy_out |-> !$rose(i_load_strobe_pin) && !$rose(i_page_latch_pin);
    endproperty
    a_no_step_busy: assert property (p_no_step_busy) else $error("step while busy");
    property p_strobe_pulse;
        $rose(i_load_strobe_pin) |-> $stable(i_data) ##0 i_load_strobe_pin[*2]
            ##1 !i_load_strobe_pin;
    endproperty
    a_strobe_pulse: assert property (p_strobe_pulse) else $error("load strobe shape");
    property p_latch_pulse;
        $rose(i_page_latch_pin) |-> i_byte_select ##0 i_page_latch_pin[*2]
            ##1 !i_page_latch_pin;
    endproperty
    a_latch_pulse: assert property (p_latch_pulse) else $error("page latch shape");
    property p_wr_pulse;
        $fell(i_wr_n) |-> !i_byte_select ##0 !i_wr_n[*2] ##1 i_wr_n;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse shape");
endmodule : pfpp_checker
`default_nettype wire

// ### verif/tb.sv
// self-checking bench joining the programmer end to the device end
`timescale 1ns/10ps
`default_nettype none
module tb
    import pfpp_pkg::*;
();
    logic        i_clk_sys;
    logic        i_rstn;
    logic        req;
    logic [1:0]  kind;
    logic [1:0]  mode;
    logic        bsel;
    logic [7:0]  din;
    logic [7:0]  a;
    logic [5:0]  rd_addr;
    logic [15:0] rd_data;
    logic        prog_done;
    logic        wmode;
    logic        h_done;
    logic        h_ready;
    logic        bsy_seen;
    logic        done_seen;
    int          error_cnt;
    int          n_checks;
    pfpp_if bus ();
    pfpp_device #(.PAGE_WORDS(4), .NUM_PAGES(16), .PROG_CYCLES(10)) pfpp_device_inst (
        .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .pins(bus), .i_rd_addr(rd_addr),
        .o_rd_data(rd_data), .o_prog_done(prog_done), .o_write_mode(wmode));
    pfpp_host pfpp_host_inst (
        .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .pins(bus), .i_req(req), .i_kind(kind),
        .i_mode(mode), .i_bsel(bsel), .i_data(din), .o_ready(h_ready), .o_done(h_done));
    pfpp_checker #(.PROG_CYCLES(10)) pfpp_checker_inst (
        .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_mode_select_hi(bus.mode_select_hi),
        .i_mode_select_lo(bus.mode_select_lo), .i_byte_select(bus.byte_select),
        .i_load_strobe_pin(bus.load_strobe_pin), .i_page_latch_pin(bus.page_latch_pin),
        .i_wr_n(bus.wr_n), .i_data(bus.data), .i_ready_busy_out(bus.ready_busy_out));
    initial begin
        i_clk_sys = 1'b0;
        forever #2 i_clk_sys = ~i_clk_sys;
    end
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // one request; prog_done pulses two cycles ahead of the host's done; one more cycle is sampled after it
    task automatic step(input logic [1:0] k, input logic [1:0] m, input logic b,
                        input logic [7:0] d);
        int n;
        @(negedge i_clk_sys);
        check("host ready", 16'h1, {15'h0, h_ready});
        req = 1'b1;
        kind = k;
        mode = m;
        bsel = b;
        din = d;
        @(negedge i_clk_sys);
        req = 1'b0;
        bsy_seen = 1'b0;
        done_seen = 1'b0;
        n = 0;
        while (h_done !== 1'b1 && n < 100) begin
            @(negedge i_clk_sys);
            if (bus.ready_busy_out === 1'b0) bsy_seen = 1'b1;
            if (prog_done === 1'b1) done_seen = 1'b1;
            n++;
        end
        if (n >= 100) begin
            check("host step finished", 16'h1, 16'h0);
            close_out();
        end
        @(negedge i_clk_sys);
        if (prog_done === 1'b1) done_seen = 1'b1;
    endtask : step
    task automatic load_word(input logic [7:0] ad, input logic [15:0] w);
        step(2'h0, PFPP_MODE_ADDR, 1'b0, ad);
        step(2'h0, PFPP_MODE_DATA, 1'b0, w[7:0]);
        step(2'h0, PFPP_MODE_DATA, 1'b1, w[15:8]);
        step(2'h1, PFPP_MODE_DATA, 1'b1, 8'h00);
    endtask : load_word
    task automatic program_page(input logic exp);
        step(2'h0, PFPP_MODE_ADDR, 1'b1, 8'h00);
        step(2'h2, PFPP_MODE_DATA, 1'b0, 8'h00);
        check("busy seen", {15'h0, exp}, {15'h0, bsy_seen});
        check("prog done", {15'h0, exp}, {15'h0, done_seen});
        check("ready after", 16'h1, {15'h0, bus.ready_busy_out});
    endtask : program_page
    task automatic read_word(input logic [5:0] ad, input logic [15:0] exp);
        @(negedge i_clk_sys);
        rd_addr = ad;
        @(negedge i_clk_sys);
        check("flash word", exp, rd_data);
    endtask : read_word
    initial begin
        i_rstn = 1'b0;
        {req, kind, mode, bsel, din, a, rd_addr} = '0;
        error_cnt = 0;
        n_checks = 0;
        repeat (12) @(negedge i_clk_sys);
        i_rstn = 1'b1;
        check("ready at reset", 16'h1, {15'h0, bus.ready_busy_out});
        check("write mode at reset", 16'h0, {15'h0, wmode});
        step(2'h0, PFPP_MODE_CMD, 1'b0, PFPP_CMD_WRITE_FLASH);
        check("write mode", 16'h1, {15'h0, wmode});
        // pages 5 and 6, page index carried in the upper bits of the low byte
        for (int p = 5; p < 7; p++) begin
            for (int w = 0; w < 4; w++) begin
                a = 8'(p * 4 + w);
                load_word(a, {8'h80 | a, 8'h55 ^ a});
            end
            program_page(1'b1);
        end
        for (int i = 20; i < 28; i++) begin
            a = 8'(i);
            read_word(a[5:0], {8'h80 | a, 8'h55 ^ a});
        end
        step(2'h0, PFPP_MODE_CMD, 1'b0, PFPP_CMD_NOP);
        check("write mode off", 16'h0, {15'h0, wmode});
        load_word(8'h14, 16'h0f0f);
        program_page(1'b0);
        read_word(6'h14, {8'h94, 8'h41});
        close_out();
    end
endmodule : tb
`default_nettype wire
